// ### rtl/cfg_space_pkg.sv
/*
  constants and carriers for the configuration bit space block.
  assumes a 24-bit program address and byte-level configuration words.
*/
package cfg_space_pkg;
  localparam int          ADDR_W       = 24;
  localparam int          WORD_W       = 8;
  localparam int          CFG_WORDS    = 8;
  localparam int          IDX_W        = 3;
  localparam logic [23:0] CFG_BASE     = 24'hF80000;
  localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
  localparam logic [23:0] CFG_SPACE_HI = 24'hFFFFFF;
  localparam logic [7:0]  ERASED_WORD  = 8'hFF;
  localparam logic [7:0]  ZERO_WORD    = 8'h00;

  typedef enum logic [1:0] {
    ACC_DATA,
    ACC_FETCH,
    ACC_TBLRD,
    ACC_TBLWR
  } acc_kind_e;

  typedef struct packed {
    logic             valid;
    acc_kind_e        kind;
    logic [23:0]      addr;
    logic [7:0]       wdata;
  } core_req_s;

  typedef struct packed {
    logic             ready;
    logic             refused;
    logic [7:0]       rdata;
  } core_rsp_s;
endpackage

// ### rtl/cfg_word_mem.sv
/*
  small configuration word store with registered read data.
  assumes one clock; writes only clear bits, as an unprogrammed cell is one.
*/
`timescale 1ns/100ps
module cfg_word_mem #(
  parameter int DEPTH = 8,
  parameter int IDX_W = 3,
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             we_i,
  input  wire logic [IDX_W-1:0] widx_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [IDX_W-1:0] ridx_i,
  output logic      [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '1;
      rdata_o <= '1;
    end
    else
    begin
      // programming only drives bits to zero
      if (we_i)
        mem_q[widx_i] <= mem_q[widx_i] & wdata_i;
      rdata_o <= mem_q[ridx_i];
    end
  end

  prog_clear_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    we_i |=> (mem_q[$past(widx_i)] & ~$past(wdata_i)) == '0)
    else $error("programming left a one bit set");
endmodule

// ### rtl/config_bit_space_access.sv
/*
  configuration bit space: store, table access and reset-time option latch.
  assumes the core holds a request until ready and reset lasts CFG_WORDS+1 clocks
  before the core acts on the option outputs.
*/
`timescale 1ns/100ps
module config_bit_space_access
  import cfg_space_pkg::*;
#(
  parameter int NWORDS = cfg_space_pkg::CFG_WORDS
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           rstn_i,
  input  wire cfg_space_pkg::core_req_s       req_i,
  output cfg_space_pkg::core_rsp_s            rsp_o,
  output logic [cfg_space_pkg::CFG_WORDS*cfg_space_pkg::WORD_W-1:0] options_o,
  output logic                                options_valid_o
);
  import cfg_space_pkg::*;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_LOAD_LAST,
    ST_RUN,
    ST_READ
  } state_e;

  state_e                     state_q;
  state_e                     state_d;
  logic [IDX_W-1:0]           load_idx_q;
  logic [IDX_W-1:0]           load_prev_q;
  logic [CFG_WORDS*WORD_W-1:0] opt_q;
  logic                       valid_q;
  logic [WORD_W-1:0]          rdata_q;
  logic [WORD_W-1:0]          mem_rdata;

  function automatic logic in_region(input logic [ADDR_W-1:0] a);
    return (a >= CFG_SPACE_LO) && (a <= CFG_SPACE_HI);
  endfunction

  function automatic logic in_cfg(input logic [ADDR_W-1:0] a);
    return (a >= CFG_BASE) && (a < CFG_BASE + ADDR_W'(NWORDS));
  endfunction

  // region and word decode
  wire              hit_region = req_i.valid && in_region(req_i.addr);
  wire              is_table   = (req_i.kind == ACC_TBLRD) || (req_i.kind == ACC_TBLWR);
  wire              allowed    = hit_region && is_table;
  wire              hit_word   = allowed && in_cfg(req_i.addr);
  wire [ADDR_W-1:0] offs       = req_i.addr - CFG_BASE;
  wire [IDX_W-1:0]  word_idx   = offs[IDX_W-1:0];
  wire              run        = (state_q == ST_RUN);
  wire              wr_en      = run && hit_word && (req_i.kind == ACC_TBLWR);
  wire              rd_start   = run && hit_word && (req_i.kind == ACC_TBLRD);
  wire [IDX_W-1:0]  ridx       = (state_q == ST_RUN || state_q == ST_READ) ? word_idx : load_idx_q;
  wire              load_done  = (load_idx_q == IDX_W'(NWORDS - 1));
  wire              opt_we     = (state_q == ST_LOAD && load_idx_q != '0) || (state_q == ST_LOAD_LAST);
  wire              st_read    = (state_q == ST_READ);
  wire              rd_erased  = run && allowed && !hit_word && (req_i.kind == ACC_TBLRD);

  cfg_word_mem #(
    .DEPTH(NWORDS),
    .IDX_W(IDX_W),
    .WIDTH(WORD_W)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .rstn_i    (rstn_i),
    .we_i      (wr_en),
    .widx_i    (word_idx),
    .wdata_i   (req_i.wdata),
    .ridx_i    (ridx),
    .rdata_o   (mem_rdata)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD:
        if (load_done)
          state_d = ST_LOAD_LAST;
      ST_LOAD_LAST:
        state_d = ST_RUN;
      ST_RUN:
        if (rd_start)
          state_d = ST_READ;
      ST_READ:
        state_d = ST_RUN;
    endcase
  end

  // fsm and load counter
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q     <= ST_LOAD;
      load_idx_q  <= '0;
      load_prev_q <= '0;
    end
    else
    begin
      state_q     <= state_d;
      load_prev_q <= load_idx_q;
      if (state_q == ST_LOAD)
        load_idx_q <= load_idx_q + IDX_W'(1);
    end
  end

  // sample words once after reset; reset also erases the store, so later programming never reaches the options
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      opt_q   <= '1;
      valid_q <= 1'b0;
    end
    else
    begin
      if (opt_we)
        opt_q[load_prev_q*WORD_W +: WORD_W] <= mem_rdata;
      if (state_q == ST_LOAD_LAST)
        valid_q <= 1'b1;
    end
  end

  // read data held after the answer until the next table read
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_q <= ERASED_WORD;
    else if (st_read)
      rdata_q <= mem_rdata;
    else if (rd_erased)
      rdata_q <= ERASED_WORD;
  end

  // unmapped but allowed reads see erased cells; refused accesses return zero
  wire refuse = req_i.valid && hit_region && !is_table;
  assign rsp_o.ready   = (state_q == ST_READ) || (run && req_i.valid && !rd_start);
  assign rsp_o.refused = refuse;
  // answers in the ready cycle itself; rdata_q only keeps the word afterwards
  assign rsp_o.rdata   = refuse    ? ZERO_WORD   :
                         st_read   ? mem_rdata   :
                         rd_erased ? ERASED_WORD : rdata_q;
  assign options_o       = opt_q;
  assign options_valid_o = valid_q;

  opts_stable_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $past(valid_q) && valid_q |-> $stable(opt_q))
    else $error("options changed after latch");
  fetch_refused_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    req_i.valid && in_region(req_i.addr) && (req_i.kind == ACC_FETCH || req_i.kind == ACC_DATA)
      |-> rsp_o.refused && !wr_en)
    else $error("non-table access reached config region");
  base_region_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_en |-> in_region(req_i.addr))
    else $error("config write outside region");
  load_time_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(valid_q) |-> $past(state_q) == ST_LOAD_LAST)
    else $error("options valid at wrong time");
  read_word_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rd_start |=> (rsp_o.ready && rsp_o.rdata == mem_rdata) ##1 (rdata_q == $past(mem_rdata)))
    else $error("table read data mismatch");
  erased_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    run && allowed && !hit_word && req_i.kind == ACC_TBLRD |=> rdata_q == ERASED_WORD)
    else $error("unmapped read not one");
  no_run_load_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !valid_q |-> !wr_en)
    else $error("write during load");
  read_ready_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rd_start |=> rsp_o.ready)
    else $error("read answer late");

  load_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !valid_q |-> !rsp_o.ready)
    else $error("answer given during load");

  valid_held_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    valid_q |=> valid_q)
    else $error("options valid dropped");

  load_end_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    state_q == ST_LOAD_LAST |=> valid_q && state_q == ST_RUN)
    else $error("load did not hand over");

  load_count_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(valid_q) |-> $past(load_idx_q, 2) == IDX_W'(NWORDS - 1))
    else $error("load covered wrong word count");

  load_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !run |-> !wr_en && !rd_start)
    else $error("table access taken outside run");

  erased_answer_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rd_erased |-> rsp_o.ready && rsp_o.rdata == ERASED_WORD)
    else $error("unmapped read answer not erased");

  refused_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rsp_o.refused |-> rsp_o.rdata == ZERO_WORD && rsp_o.ready == run)
    else $error("refused access answered wrongly");

  idle_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !req_i.valid |-> !rsp_o.ready && !rsp_o.refused)
    else $error("answer without request");

  write_ack_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_en |-> rsp_o.ready && !rsp_o.refused)
    else $error("table write not acknowledged");

  read_single_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    st_read |=> state_q == ST_RUN)
    else $error("read state held too long");

  user_open_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    req_i.valid && !in_region(req_i.addr) |-> !rsp_o.refused && !wr_en && !rd_start)
    else $error("user space access touched config");

  table_only_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    req_i.valid && !is_table |-> !wr_en && !rd_start && !rd_erased)
    else $error("plain access used table path");
endmodule

// ### tb/core_model.sv
/*
  core side model: issues one table or plain access at a time and waits for ready.
  assumes ready is sampled at rising edges and the request stands until then.
*/
`timescale 1ns/100ps
module core_model (
  input  wire logic                     core_clk_i,
  output cfg_space_pkg::core_req_s      req_o,
  input  wire cfg_space_pkg::core_rsp_s rsp_i
);
  import cfg_space_pkg::*;
  initial req_o = '{valid: 1'b0, kind: ACC_TBLRD, addr: 24'h000000, wdata: 8'h00};
  // a timed-out access returns unknowns, so any compare on it fails
  task automatic access(input acc_kind_e k, input logic [23:0] a, input logic [7:0] w,
                        output logic [7:0] rd, output logic rf);
    rd = 'x;
    rf = 'x;
    @(posedge core_clk_i);
    req_o <= '{valid: 1'b1, kind: k, addr: a, wdata: w};
    for (int n = 0; n < 16; n++)
    begin
      @(posedge core_clk_i);
      if (rsp_i.ready === 1'b1)
      begin
        rd = rsp_i.rdata;
        rf = rsp_i.refused;
        break;
      end
    end
    // released address and data lines show the inverse, not the last value; kind keeps its value
    req_o <= '{valid: 1'b0, kind: k, addr: ~a, wdata: ~w};
  endtask
endmodule

// ### tb/config_bit_space_access_tb.sv
/*
  self-checking bench for the configuration bit space block.
  assumes the core model in core_model.sv and the package cfg_space_pkg.
*/
`timescale 1ns/100ps
module config_bit_space_access_tb;
  import cfg_space_pkg::*;
  logic        core_clk_i;
  logic        rstn_i;
  core_req_s   req;
  core_rsp_s   rsp;
  logic [63:0] options;
  logic        options_valid;
  int          miscompares;
  int          total_checks;
  logic [31:0] seed;
  logic [7:0]  exp_mem [CFG_WORDS];
  logic [7:0]  rd;
  logic        rf;
  int          idx;
  config_bit_space_access i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req), .rsp_o(rsp),
                                 .options_o(options), .options_valid_o(options_valid));
  core_model i_core (.core_clk_i(core_clk_i), .req_o(req), .rsp_i(rsp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset;
    rstn_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    check("valid_in_reset", 64'(1'b0), 64'(options_valid));
    rstn_i <= 1'b1;
    for (int n = 0; n < 20 && options_valid !== 1'b1; n++) @(posedge core_clk_i);
    check("options_valid", 64'(1'b1), 64'(options_valid));
    check("options_erased", {8{ERASED_WORD}}, options);
    foreach (exp_mem[i]) exp_mem[i] = ERASED_WORD;
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    seed = 32'h2ca89c7e;
    rstn_i = 1'b0;
    do_reset();
    exp_mem[7] = ZERO_WORD;
    i_core.access(ACC_TBLWR, 24'(CFG_BASE + 7), ZERO_WORD, rd, rf);
    check("tblwr_first", 64'(1'b0), 64'(rf));
    // random programming; a write can only clear bits
    repeat (24)
    begin
      seed = lfsr(seed);
      idx = int'(seed[IDX_W-1:0]);
      exp_mem[idx] &= seed[15:8];
      i_core.access(ACC_TBLWR, 24'(CFG_BASE + idx), seed[15:8], rd, rf);
      check("tblwr_refused", 64'(1'b0), 64'(rf));
    end
    // one past the last word: allowed, but must not wrap onto word 0
    i_core.access(ACC_TBLWR, 24'(CFG_BASE + CFG_WORDS), ZERO_WORD, rd, rf);
    check("tblwr_past_end", 64'(1'b0), 64'(rf));
    for (int i = 0; i < CFG_WORDS; i++)
    begin
      i_core.access(ACC_TBLRD, 24'(CFG_BASE + i), 8'h00, rd, rf);
      check("tblrd_word", 64'(exp_mem[i]), 64'(rd));
    end
    check("options_held", {8{ERASED_WORD}}, options);
    for (int j = 0; j < 2; j++)
    begin
      i_core.access(j ? ACC_FETCH : ACC_DATA, CFG_BASE, 8'h00, rd, rf);
      check("base_refused", 64'(1'b1), 64'(rf));
      check("refused_rdata", 64'(ZERO_WORD), 64'(rd));
      i_core.access(j ? ACC_FETCH : ACC_DATA, CFG_SPACE_LO, 8'h00, rd, rf);
      check("region_lo_refused", 64'(1'b1), 64'(rf));
      i_core.access(j ? ACC_FETCH : ACC_DATA, 24'h000200, 8'h00, rd, rf);
      check("user_space_open", 64'(1'b0), 64'(rf));
    end
    i_core.access(ACC_TBLRD, CFG_SPACE_HI, 8'h00, rd, rf);
    check("region_hi_tblrd", 64'(1'b0), 64'(rf));
    check("region_hi_erased", 64'(ERASED_WORD), 64'(rd));
    do_reset();
    i_core.access(ACC_TBLRD, CFG_BASE, 8'h00, rd, rf);
    check("tblrd_after_reset", 64'(ERASED_WORD), 64'(rd));
    print_verdict();
  end
endmodule
